// ===== ess_pkg.sv
// Package for the external supply switch control block.
// Assumes a single 100 MHz clock domain and APB register access.
package ess_pkg;
  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [11:0] ESS_CFG_OFF    = 12'h000;
  localparam logic [11:0] ESS_STATUS_OFF = 12'h004;
  localparam logic [11:0] ESS_PROTO_OFF  = 12'h008;
  // ==========================================================================
  // Config field positions
  localparam int ESS_COND_LSB   = 0;
  localparam int ESS_PATTERN_BIT = 3;
  localparam int ESS_IDLE_BIT   = 4;
  localparam int ESS_POL_BIT    = 5;
  localparam int ESS_LOADED_BIT = 6;
  localparam logic [6:0] ESS_CFG_RST = 7'h00;
  // ==========================================================================
  // Protocol state register bits
  localparam int ESS_PS_INIT_BIT = 0;
  localparam int ESS_PS_SL_BIT   = 1;
  localparam int ESS_PS_ST_LSB   = 4;
  // ==========================================================================
  // On-condition codes
  typedef enum logic [2:0] {
    ESS_COND_ALWAYS_ON  = 3'b100,
    ESS_COND_INVENTORY  = 3'b101,
    ESS_COND_SINGULATED = 3'b110,
    ESS_COND_SELECTED   = 3'b111
  } ess_cond_t;
  // Tag protocol states
  typedef enum logic [2:0] {
    ESS_ST_READY     = 3'b000,
    ESS_ST_ARBITRATE = 3'b001,
    ESS_ST_REPLY     = 3'b010,
    ESS_ST_ACK       = 3'b011,
    ESS_ST_OPEN      = 3'b100,
    ESS_ST_SECURED   = 3'b101,
    ESS_ST_KILLED    = 3'b110
  } ess_state_t;
endpackage

// ===== ess_pad_drv.sv
// Pad level generator for the two switch pads.
// Assumes on_state, enable and config bits are synchronous to I_CLOCK.
`timescale 1ns/100ps
module ess_pad_drv (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_enable,
  input  wire logic i_on,
  input  wire logic i_pattern,
  input  wire logic i_idle_drive,
  input  wire logic i_polarity,
  output logic      o_pad1,
  output logic      o_pad1_oe,
  output logic      o_pad2,
  output logic      o_pad2_oe
);
  logic on_lvl1;
  logic on_lvl2;
  logic drive;

  // ==========================================================================
  // ON levels
  always_comb begin
    on_lvl1 = i_pattern ? i_polarity : ~i_polarity;
    on_lvl2 = i_polarity;
  end

  assign drive = i_enable & (i_on | i_idle_drive);

  // ==========================================================================
  // Both pads switch together from one flop set
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pad1    <= 1'b0;
      o_pad2    <= 1'b0;
      o_pad1_oe <= 1'b0;
      o_pad2_oe <= 1'b0;
    end else begin
      o_pad1    <= i_on ? on_lvl1 : ~on_lvl1;
      o_pad2    <= i_on ? on_lvl2 : ~on_lvl2;
      o_pad1_oe <= drive;
      o_pad2_oe <= drive;
    end
  end

  property p_oe_pair;
    @(posedge i_clk) disable iff (!i_rst_b) o_pad1_oe == o_pad2_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("Pad enables differ");

  property p_on_levels;
    @(posedge i_clk) disable iff (!i_rst_b)
      (i_enable && i_on && !i_pattern) |=> (o_pad1 != o_pad2) && o_pad2 == $past(i_polarity);
  endproperty
  a_on_levels: assert property (p_on_levels) else $error("Wrong ON levels");

  property p_idle_float;
    @(posedge i_clk) disable iff (!i_rst_b) (!i_on && !i_idle_drive) |=> !o_pad1_oe;
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("Idle pads driven");
endmodule

// ===== ess_top.sv
// Top of the external supply switch control with APB slave.
// Assumes protocol state inputs come from another clock domain or pins.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/100ps
module ess_top
  import ess_pkg::*;
(
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST_B,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  input  wire logic        I_INIT_DONE,
  input  wire logic        I_SL_FLAG,
  input  wire logic [2:0]  I_TAG_STATE,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic             O_FIRST_SWITCH_PAD,
  output logic             O_FIRST_SWITCH_PAD_OE,
  output logic             O_SECOND_SWITCH_PAD,
  output logic             O_SECOND_SWITCH_PAD_OE
);
  logic [6:0] cfg_q;
  logic [2:0] init_sync_q;
  logic [2:0] sl_sync_q;
  logic [2:0] st_s1_q;
  logic [2:0] st_s2_q;
  logic [2:0] st_s3_q;
  logic       init_q;
  logic       sl_q;
  logic [2:0] state_q;
  logic       on_d;
  logic       on_q;
  logic       enable;
  logic       wr_en;
  logic       mapped;
  logic [31:0] rdata_d;
  logic [2:0] cond;

  // ==========================================================================
  // Input synchronisers: accept a change once stages two and three agree
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      init_sync_q <= 3'h0;
      sl_sync_q   <= 3'h0;
      st_s1_q     <= 3'h0;
      st_s2_q     <= 3'h0;
      st_s3_q     <= 3'h0;
    end else begin
      init_sync_q <= {init_sync_q[1:0], I_INIT_DONE};
      sl_sync_q   <= {sl_sync_q[1:0], I_SL_FLAG};
      st_s1_q     <= I_TAG_STATE;
      st_s2_q     <= st_s1_q;
      st_s3_q     <= st_s2_q;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      init_q  <= 1'b0;
      sl_q    <= 1'b0;
      state_q <= ESS_ST_READY;
    end else begin
      if (init_sync_q[2] == init_sync_q[1]) init_q <= init_sync_q[2];
      if (sl_sync_q[2] == sl_sync_q[1]) sl_q <= sl_sync_q[2];
      if (st_s3_q == st_s2_q) state_q <= st_s3_q;
    end
  end

  // ==========================================================================
  // APB slave, zero wait states
  assign wr_en     = I_PSEL & I_PENABLE & I_PWRITE;
  assign O_PREADY  = 1'b1;
  assign mapped    = (I_PADDR == ESS_CFG_OFF) || (I_PADDR == ESS_STATUS_OFF) || (I_PADDR == ESS_PROTO_OFF);
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cfg_q <= ESS_CFG_RST;
    end else if (wr_en && I_PADDR == ESS_CFG_OFF) begin
      cfg_q <= I_PWDATA[6:0];
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (I_PADDR)
      ESS_CFG_OFF:    rdata_d = {25'h000_0000, cfg_q};
      ESS_STATUS_OFF: rdata_d = {28'h000_0000, O_SECOND_SWITCH_PAD_OE, enable, on_q, O_FIRST_SWITCH_PAD};
      ESS_PROTO_OFF:  rdata_d = {25'h000_0000, state_q, 2'b00, sl_q, init_q};
      default:        rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data registered during setup so it is stable in the access phase
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PRDATA <= 32'h0000_0000;
    end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
      O_PRDATA <= rdata_d;
    end
  end

  // ==========================================================================
  // On-condition evaluation
  assign cond   = cfg_q[ESS_COND_LSB +: 3];
  assign enable = cfg_q[ESS_LOADED_BIT] & init_q;

  always_comb begin
    on_d = 1'b0;
    if (!cond[2]) begin
      on_d = 1'b0;
    end else begin
      case (cond)
        ESS_COND_ALWAYS_ON:  on_d = 1'b1;
        ESS_COND_INVENTORY:  on_d = (state_q == ESS_ST_ARBITRATE) || (state_q == ESS_ST_REPLY) ||
                                    (state_q == ESS_ST_ACK) || (state_q == ESS_ST_OPEN) ||
                                    (state_q == ESS_ST_SECURED);
        ESS_COND_SINGULATED: on_d = (state_q == ESS_ST_ACK) || (state_q == ESS_ST_OPEN) ||
                                    (state_q == ESS_ST_SECURED);
        ESS_COND_SELECTED:   on_d = sl_q;
        default:             on_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      on_q <= 1'b0;
    end else begin
      on_q <= on_d & enable;
    end
  end

  // ==========================================================================
  // Pad drivers
  ess_pad_drv u_pad_drv (
    .i_clk        (I_CLOCK),
    .i_rst_b      (I_RST_B),
    .i_enable     (enable),
    .i_on         (on_q),
    .i_pattern    (cfg_q[ESS_PATTERN_BIT]),
    .i_idle_drive (cfg_q[ESS_IDLE_BIT]),
    .i_polarity   (cfg_q[ESS_POL_BIT]),
    .o_pad1       (O_FIRST_SWITCH_PAD),
    .o_pad1_oe    (O_FIRST_SWITCH_PAD_OE),
    .o_pad2       (O_SECOND_SWITCH_PAD),
    .o_pad2_oe    (O_SECOND_SWITCH_PAD_OE)
  );

  // ==========================================================================
  property p_msb_off;
    @(posedge I_CLOCK) disable iff (!I_RST_B) !cfg_q[2] |=> !on_q;
  endproperty
  a_msb_off: assert property (p_msb_off) else $error("ON with condition MSB clear");

  property p_always_on;
    @(posedge I_CLOCK) disable iff (!I_RST_B) (cond == 3'b100 && enable) |=> on_q;
  endproperty
  a_always_on: assert property (p_always_on) else $error("Always-on mode not ON");

  property p_inventory;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
      (cond == 3'b101 && enable && state_q == ESS_ST_READY) |=> !on_q;
  endproperty
  a_inventory: assert property (p_inventory) else $error("ON outside inventory");

  property p_singulated;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
      (cond == 3'b110 && enable) |=> on_q == ($past(state_q) inside {3'b011, 3'b100, 3'b101});
  endproperty
  a_singulated: assert property (p_singulated) else $error("Singulated mode mismatch");

  property p_selected;
    @(posedge I_CLOCK) disable iff (!I_RST_B) (cond == 3'b111 && enable) |=> on_q == $past(sl_q);
  endproperty
  a_selected: assert property (p_selected) else $error("Selected mode mismatch");

  property p_float_before_init;
    @(posedge I_CLOCK) disable iff (!I_RST_B) !enable |=> !O_FIRST_SWITCH_PAD_OE;
  endproperty
  a_float_before_init: assert property (p_float_before_init) else $error("Pad driven before init");

  property p_field_lost;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
      !init_q |=> !on_q && !O_FIRST_SWITCH_PAD_OE && !O_SECOND_SWITCH_PAD_OE;
  endproperty
  a_field_lost: assert property (p_field_lost) else $error("Pads kept ON without init");

  property p_killed_off;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
      (cond == ESS_COND_INVENTORY && state_q == ESS_ST_KILLED) |=> !on_q;
  endproperty
  a_killed_off: assert property (p_killed_off) else $error("ON in killed state");

  property p_idle_driven;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
      (enable && !on_q && cfg_q[ESS_IDLE_BIT]) |=> O_FIRST_SWITCH_PAD_OE && O_SECOND_SWITCH_PAD_OE;
  endproperty
  a_idle_driven: assert property (p_idle_driven) else $error("OFF pads not driven");

  property p_idle_levels;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
      (enable && !on_q && !cfg_q[ESS_PATTERN_BIT])
        |=> (O_FIRST_SWITCH_PAD == $past(cfg_q[ESS_POL_BIT])) && (O_SECOND_SWITCH_PAD != O_FIRST_SWITCH_PAD);
  endproperty
  a_idle_levels: assert property (p_idle_levels) else $error("OFF levels not opposite of ON");

  property p_pair_levels;
    @(posedge I_CLOCK) disable iff (!I_RST_B)
      (enable && cfg_q[ESS_PATTERN_BIT]) |=> O_FIRST_SWITCH_PAD == O_SECOND_SWITCH_PAD;
  endproperty
  a_pair_levels: assert property (p_pair_levels) else $error("Common pattern levels differ");
endmodule

// ===== ess_ext_dev.sv
// Model of the external device hung between the two switch pads.
// Assumes pad outputs and enables come straight from the switch control top.
`timescale 1ns/100ps
module ess_ext_dev (
  input  wire logic i_clk,
  input  wire logic i_pad1,
  input  wire logic i_pad1_oe,
  input  wire logic i_pad2,
  input  wire logic i_pad2_oe,
  output logic      o_wire1,
  output logic      o_wire2,
  output logic      o_powered
);
  logic last1_q;
  logic last2_q;
  // ====================
  // Wire levels
  always_ff @(posedge i_clk) begin
    if (i_pad1_oe) last1_q <= i_pad1;
    if (i_pad2_oe) last2_q <= i_pad2;
  end
  // No pull on the pads: a released pad drifts away from its last level
  assign o_wire1   = i_pad1_oe ? i_pad1 : ~last1_q;
  assign o_wire2   = i_pad2_oe ? i_pad2 : ~last2_q;
  assign o_powered = i_pad1_oe & i_pad2_oe & (i_pad1 ^ i_pad2);
endmodule

// ===== tb_top.sv
// Testbench for the external supply switch control top.
// Assumes APB with zero wait states and about six cycles of pad latency.
`timescale 1ns/100ps
module tb_top import ess_pkg::*; ;
  typedef struct packed {
    logic [6:0] cfg;
    logic       init;
    logic       sl;
    logic [2:0] st;
    logic [3:0] exp;
  } ess_row_t;
  logic        clk, rst_b, psel, pen, pwr, init, sl, pready, slverr;
  logic        p1, oe1, p2, oe2, w1, w2, pwr_ok, err;
  logic [2:0]  st;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch = 0;
  int          checks = 0;
  // Expected nibble: first pad oe, level, second pad oe, level
  ess_row_t rows [24] = '{
    '{7'h44,1'h1,1'h0,3'h0,4'hE}, '{7'h64,1'h1,1'h0,3'h0,4'hB}, '{7'h74,1'h1,1'h0,3'h0,4'hB},
    '{7'h4C,1'h1,1'h0,3'h0,4'hA}, '{7'h6C,1'h1,1'h0,3'h0,4'hF}, '{7'h44,1'h0,1'h0,3'h0,4'h0},
    '{7'h50,1'h1,1'h0,3'h0,4'hB}, '{7'h73,1'h1,1'h1,3'h4,4'hE}, '{7'h5B,1'h1,1'h0,3'h0,4'hF},
    '{7'h7B,1'h1,1'h0,3'h0,4'hA}, '{7'h40,1'h1,1'h1,3'h3,4'h0}, '{7'h45,1'h1,1'h0,3'h0,4'h0},
    '{7'h45,1'h1,1'h0,3'h1,4'hE}, '{7'h45,1'h1,1'h0,3'h2,4'hE}, '{7'h45,1'h1,1'h0,3'h5,4'hE},
    '{7'h45,1'h1,1'h0,3'h6,4'h0}, '{7'h55,1'h1,1'h0,3'h6,4'hB}, '{7'h46,1'h1,1'h0,3'h2,4'h0},
    '{7'h46,1'h1,1'h0,3'h3,4'hE}, '{7'h46,1'h1,1'h0,3'h4,4'hE}, '{7'h47,1'h1,1'h1,3'h0,4'hE},
    '{7'h47,1'h1,1'h0,3'h3,4'h0}, '{7'h04,1'h1,1'h0,3'h0,4'h0}, '{7'h47,1'h0,1'h1,3'h0,4'h0}};

  ess_top DUT (.I_CLOCK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .I_INIT_DONE(init), .I_SL_FLAG(sl), .I_TAG_STATE(st),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(slverr), .O_FIRST_SWITCH_PAD(p1),
    .O_FIRST_SWITCH_PAD_OE(oe1), .O_SECOND_SWITCH_PAD(p2), .O_SECOND_SWITCH_PAD_OE(oe2));
  ess_ext_dev u_dev (.i_clk(clk), .i_pad1(p1), .i_pad1_oe(oe1), .i_pad2(p2), .i_pad2_oe(oe2),
    .o_wire1(w1), .o_wire2(w2), .o_powered(pwr_ok));

  // ====================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string msg);
    checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h want %h", $time, msg, seen, want);
    end
  endtask
  // Leading edge keeps back-to-back calls from driving twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ====================
  // Clock, watchdog, tests
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #300us;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    rst_b = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    init = 1'b0; sl = 1'b0; st = 3'h0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, ESS_CFG_OFF, 32'h0);
    check(rd, 32'h0, "cfg reset");
    check({oe1, oe2}, 2'h0, "pads after reset");
    $display("test reset done");
    foreach (rows[i]) begin
      init <= rows[i].init;
      sl <= rows[i].sl;
      st <= rows[i].st;
      apb(1'b1, ESS_CFG_OFF, {25'h0, rows[i].cfg});
      apb(1'b0, ESS_CFG_OFF, 32'h0);
      check(rd[6:0], rows[i].cfg, "cfg readback");
      repeat (10) @(posedge clk);
      check({oe1, oe2}, {rows[i].exp[3], rows[i].exp[1]}, "pad drive");
      if (rows[i].exp[3]) check({w1, w2}, {rows[i].exp[2], rows[i].exp[0]}, "pad levels");
      check(pwr_ok, rows[i].exp[3] & (rows[i].exp[2] ^ rows[i].exp[0]), "supply");
    end
    $display("test table done");
    apb(1'b0, ESS_PROTO_OFF, 32'h0);
    check({rd[6:4], rd[1:0]}, 5'h02, "proto status");
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    check(err, 1'b1, "unmapped write");
    apb(1'b0, 12'h00C, 32'h0);
    check(err, 1'b1, "unmapped read error");
    check(rd, 32'h0, "unmapped read data");
    apb(1'b0, ESS_CFG_OFF, 32'h0);
    check(rd[6:0], 7'h47, "cfg kept");
    $display("test unmapped done");
    init <= 1'b1;
    apb(1'b1, ESS_CFG_OFF, 32'h44);
    repeat (10) @(posedge clk);
    check({oe1, oe2}, 2'h3, "on before reset");
    apb(1'b0, ESS_STATUS_OFF, 32'h0);
    check(err, 1'b0, "status read error");
    check(rd, 32'h0000_000F, "status while on");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    check({oe1, oe2}, 2'h0, "float in reset");
    rst_b <= 1'b1;
    apb(1'b0, ESS_CFG_OFF, 32'h0);
    check(rd, 32'h0, "cfg after reset");
    repeat (10) @(posedge clk);
    check({oe1, oe2}, 2'h0, "float until loaded");
    $display("test mid reset done");
    report_and_stop();
  end
endmodule
